// file: common/switch_table_pkg.sv
`default_nettype none
package switch_table_pkg;

  // Register byte addresses
  localparam logic [15:0] ADDR_VLAN_ENTRY0 = 16'h0400;
  localparam logic [15:0] ADDR_VLAN_ENTRY1 = 16'h0404;
  localparam logic [15:0] ADDR_VLAN_ENTRY2 = 16'h0408;
  localparam logic [15:0] ADDR_VLAN_INDEX = 16'h040C;
  localparam logic [15:0] ADDR_VLAN_CTRL = 16'h0410;
  localparam logic [15:0] ADDR_STA_CTRL = 16'h041C;
  localparam logic [15:0] ADDR_STA_WORD2 = 16'h0424;
  localparam logic [15:0] ADDR_STA_WORD3 = 16'h0428;
  localparam logic [15:0] ADDR_STA_WORD4 = 16'h042C;

  // Control fields; go and action are shared, table select and index are static control only
  localparam int GO_BIT = 7;
  localparam int ACTION_BIT = 0;
  localparam int TSEL_BIT = 4;
  localparam int IDX_LSB = 8;
  localparam int IDX_MSB = 13;
  localparam int VIDX_MSB = 11;

  // Static word 2 and 3 fields
  localparam int BYPASS_BIT = 31;
  localparam int MCMATCH_BIT = 30;
  localparam int FWD_MSB = 5;
  localparam int FID_LSB = 16;
  localparam int FID_MSB = 22;
  localparam int MACHI_MSB = 15;

  // VLAN entry 0 fields; entry 1 holds untag, entry 2 holds membership
  localparam int V_VALID_BIT = 31;
  localparam int V_FOPT_BIT = 30;
  localparam int V_PRIO_LSB = 27;
  localparam int V_STP_LSB = 24;
  localparam int V_PORT_MSB = 6;

  // Reserved multicast table
  localparam int RMC_ADDRS = 48;
  localparam int RMC_GROUPS = 8;
  localparam int RMC_GRP_SIZE = RMC_ADDRS / RMC_GROUPS;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef struct packed {
    logic port_state_bypass;
    logic multicast_group_match_enable;
    logic [5:0] fwd_mask;
    logic [6:0] filter_group_id;
    logic [47:0] mac;
  } sta_entry_t;

  typedef struct packed {
    logic valid;
    logic forward_option;
    logic [2:0] priority_val;
    logic [2:0] spanning_tree_instance;
    logic [6:0] filter_group_id;
    logic [6:0] untag_mask;
    logic [6:0] member_mask;
  } vlan_entry_t;

endpackage
`default_nettype wire

// file: rtl/switch_table_indirect_access.sv
`timescale 1ns/1ps
`default_nettype none
module switch_table_indirect_access
  import switch_table_pkg::*;
#(
  parameter int STA_DEPTH = 16,
  parameter int VLAN_DEPTH = 4096
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic vlan_mode_en,
  input wire logic vlan_lookup_req,
  input wire logic [11:0] vlan_lookup_vid,
  output logic vlan_lookup_valid,
  output vlan_entry_t vlan_lookup_entry,
  input wire logic sta_lookup_req,
  input wire logic [47:0] sta_lookup_mac,
  input wire logic [6:0] sta_lookup_fid,
  input wire logic sta_lookup_mcast,
  input wire logic [5:0] port_state_fwd,
  output logic sta_lookup_valid,
  output logic sta_lookup_hit,
  output logic [5:0] sta_lookup_fwd,
  input wire logic [5:0] rmc_lookup_addr,
  output logic [5:0] rmc_lookup_fwd
);

  typedef enum {ST_IDLE, ST_STA, ST_VLAN} op_state_t;

  op_state_t state_reg;
  sta_entry_t sta_mem [STA_DEPTH];
  logic [5:0] rmc_mem [RMC_GROUPS];
  vlan_entry_t vlan_mem [VLAN_DEPTH];

  // Shared data words, only defined bits are stored
  logic bypass_reg;
  logic mcmatch_reg;
  logic [5:0] fwd_reg;
  logic [6:0] fid_reg;
  logic [47:0] mac_reg;
  vlan_entry_t vdata_reg;
  logic [11:0] vidx_reg;

  // Control registers
  logic sta_go_reg;
  logic sta_read_reg;
  logic sta_tsel_reg;
  logic [5:0] sta_idx_reg;
  logic vlan_go_reg;
  logic vlan_read_reg;

  logic wr_sta_ctrl;
  logic wr_vlan_ctrl;
  logic [2:0] rmc_grp;
  logic rmc_idx_ok;
  logic sta_idx_ok;
  logic [STA_DEPTH-1:0] sta_match;

  assign wr_sta_ctrl = reg_wr && (reg_addr == ADDR_STA_CTRL) && !sta_go_reg;
  assign wr_vlan_ctrl = reg_wr && (reg_addr == ADDR_VLAN_CTRL) && !vlan_go_reg;
  // Eight fixed groups of six consecutive reserved addresses
  assign rmc_grp = 3'(sta_idx_reg / 6'(RMC_GRP_SIZE));
  assign rmc_idx_ok = (sta_idx_reg < 6'(RMC_ADDRS));
  assign sta_idx_ok = (sta_idx_reg < 6'(STA_DEPTH));

  // Static and reserved multicast control, go cleared when the access ends
  always_ff @(posedge mclk) begin
    if (srst) begin
      sta_go_reg <= 1'b0;
      sta_read_reg <= 1'b0;
      sta_tsel_reg <= 1'b0;
      sta_idx_reg <= 6'h00;
    end else if (wr_sta_ctrl) begin
      sta_go_reg <= reg_wdata[GO_BIT];
      sta_read_reg <= reg_wdata[ACTION_BIT];
      sta_tsel_reg <= reg_wdata[TSEL_BIT];
      sta_idx_reg <= reg_wdata[IDX_MSB:IDX_LSB];
    end else if (state_reg == ST_STA) begin
      sta_go_reg <= 1'b0;
    end
  end

  // VLAN access control and index
  always_ff @(posedge mclk) begin
    if (srst) begin
      vlan_go_reg <= 1'b0;
      vlan_read_reg <= 1'b0;
      vidx_reg <= 12'h000;
    end else begin
      if (wr_vlan_ctrl) begin
        vlan_go_reg <= reg_wdata[GO_BIT];
        vlan_read_reg <= reg_wdata[ACTION_BIT];
      end else if (state_reg == ST_VLAN) begin
        vlan_go_reg <= 1'b0;
      end
      if (reg_wr && reg_addr == ADDR_VLAN_INDEX && !vlan_go_reg) begin
        vidx_reg <= reg_wdata[VIDX_MSB:0];
      end
    end
  end

  // Access sequencer, static side served first
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (sta_go_reg) begin
            state_reg <= ST_STA;
          end else if (vlan_go_reg) begin
            state_reg <= ST_VLAN;
          end
        end
        ST_STA: state_reg <= ST_IDLE;
        ST_VLAN: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Static data words: host writes or read results
  always_ff @(posedge mclk) begin
    if (srst) begin
      bypass_reg <= 1'b0;
      mcmatch_reg <= 1'b0;
      fwd_reg <= 6'h00;
      fid_reg <= 7'h00;
      mac_reg <= 48'h0000_0000_0000;
    end else if (state_reg == ST_STA && sta_read_reg) begin
      if (sta_tsel_reg) begin
        bypass_reg <= 1'b0;
        mcmatch_reg <= 1'b0;
        fwd_reg <= rmc_idx_ok ? rmc_mem[rmc_grp] : 6'h00;
      end else if (sta_idx_ok) begin
        bypass_reg <= sta_mem[sta_idx_reg[3:0]].port_state_bypass;
        mcmatch_reg <= sta_mem[sta_idx_reg[3:0]].multicast_group_match_enable;
        fwd_reg <= sta_mem[sta_idx_reg[3:0]].fwd_mask;
        fid_reg <= sta_mem[sta_idx_reg[3:0]].filter_group_id;
        mac_reg <= sta_mem[sta_idx_reg[3:0]].mac;
      end
    end else if (reg_wr && !sta_go_reg) begin
      if (reg_addr == ADDR_STA_WORD2) begin
        bypass_reg <= reg_wdata[BYPASS_BIT];
        mcmatch_reg <= reg_wdata[MCMATCH_BIT];
        fwd_reg <= reg_wdata[FWD_MSB:0];
      end
      if (reg_addr == ADDR_STA_WORD3) begin
        fid_reg <= reg_wdata[FID_MSB:FID_LSB];
        mac_reg[47:32] <= reg_wdata[MACHI_MSB:0];
      end
      if (reg_addr == ADDR_STA_WORD4) begin
        mac_reg[31:0] <= reg_wdata;
      end
    end
  end

  // Static and reserved table writes
  always_ff @(posedge mclk) begin
    if (state_reg == ST_STA && !sta_read_reg) begin
      if (sta_tsel_reg && rmc_idx_ok) begin
        rmc_mem[rmc_grp] <= fwd_reg;
      end else if (!sta_tsel_reg && sta_idx_ok) begin
        sta_mem[sta_idx_reg[3:0]] <= '{bypass_reg, mcmatch_reg, fwd_reg, fid_reg, mac_reg};
      end
    end
  end

  // VLAN data words
  always_ff @(posedge mclk) begin
    if (srst) begin
      vdata_reg <= '0;
    end else if (state_reg == ST_VLAN && vlan_read_reg) begin
      vdata_reg <= vlan_mem[vidx_reg];
    end else if (reg_wr && !vlan_go_reg) begin
      if (reg_addr == ADDR_VLAN_ENTRY0) begin
        vdata_reg.valid <= reg_wdata[V_VALID_BIT];
        vdata_reg.forward_option <= reg_wdata[V_FOPT_BIT];
        vdata_reg.priority_val <= reg_wdata[V_PRIO_LSB+:3];
        vdata_reg.spanning_tree_instance <= reg_wdata[V_STP_LSB+:3];
        vdata_reg.filter_group_id <= reg_wdata[FID_MSB:FID_LSB];
      end
      if (reg_addr == ADDR_VLAN_ENTRY1) begin
        vdata_reg.untag_mask <= reg_wdata[V_PORT_MSB:0];
      end
      if (reg_addr == ADDR_VLAN_ENTRY2) begin
        vdata_reg.member_mask <= reg_wdata[V_PORT_MSB:0];
      end
    end
  end

  // VLAN table write, one entry per VID
  always_ff @(posedge mclk) begin
    if (state_reg == ST_VLAN && !vlan_read_reg) begin
      vlan_mem[vidx_reg] <= vdata_reg;
    end
  end

  // Ingress VLAN lookup, answered one cycle later while the mode is on
  always_ff @(posedge mclk) begin
    if (srst) begin
      vlan_lookup_valid <= 1'b0;
      vlan_lookup_entry <= '0;
    end else begin
      vlan_lookup_valid <= vlan_lookup_req && vlan_mode_en;
      if (vlan_lookup_req && vlan_mode_en) begin
        vlan_lookup_entry <= vlan_mem[vlan_lookup_vid];
      end
    end
  end

  // Per-entry static match
  for (genvar i = 0; i < STA_DEPTH; i++) begin : g_match
    assign sta_match[i] = (sta_mem[i].mac == sta_lookup_mac) &&
        (!(sta_lookup_mcast && sta_mem[i].multicast_group_match_enable) ||
         sta_mem[i].filter_group_id == sta_lookup_fid);
  end

  // Static lookup result, lowest matching entry wins
  always_ff @(posedge mclk) begin
    if (srst) begin
      sta_lookup_valid <= 1'b0;
      sta_lookup_hit <= 1'b0;
      sta_lookup_fwd <= 6'h00;
    end else begin
      sta_lookup_valid <= sta_lookup_req;
      if (sta_lookup_req) begin
        sta_lookup_hit <= |sta_match;
        sta_lookup_fwd <= 6'h00;
        for (int k = STA_DEPTH - 1; k >= 0; k--) begin
          if (sta_match[k]) begin
            sta_lookup_fwd <= sta_mem[k].port_state_bypass ? sta_mem[k].fwd_mask :
                (sta_mem[k].fwd_mask & port_state_fwd);
          end
        end
      end
    end
  end

  // Reserved multicast lookup by low address bits
  always_ff @(posedge mclk) begin
    if (srst) begin
      rmc_lookup_fwd <= 6'h00;
    end else if (rmc_lookup_addr < 6'(RMC_ADDRS)) begin
      rmc_lookup_fwd <= rmc_mem[3'(rmc_lookup_addr / 6'(RMC_GRP_SIZE))];
    end else begin
      rmc_lookup_fwd <= 6'h00;
    end
  end

  // Register read port, one cycle latency
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= ZERO_WORD;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= ZERO_WORD;
        case (reg_addr)
          ADDR_STA_WORD2: begin
            reg_rdata[BYPASS_BIT] <= bypass_reg;
            reg_rdata[MCMATCH_BIT] <= mcmatch_reg;
            reg_rdata[FWD_MSB:0] <= fwd_reg;
          end
          ADDR_STA_WORD3: begin
            reg_rdata[FID_MSB:FID_LSB] <= fid_reg;
            reg_rdata[MACHI_MSB:0] <= mac_reg[47:32];
          end
          ADDR_STA_WORD4: reg_rdata <= mac_reg[31:0];
          ADDR_STA_CTRL: begin
            reg_rdata[GO_BIT] <= sta_go_reg;
            reg_rdata[ACTION_BIT] <= sta_read_reg;
            reg_rdata[TSEL_BIT] <= sta_tsel_reg;
            reg_rdata[IDX_MSB:IDX_LSB] <= sta_idx_reg;
          end
          ADDR_VLAN_ENTRY0: begin
            reg_rdata[V_VALID_BIT] <= vdata_reg.valid;
            reg_rdata[V_FOPT_BIT] <= vdata_reg.forward_option;
            reg_rdata[V_PRIO_LSB+:3] <= vdata_reg.priority_val;
            reg_rdata[V_STP_LSB+:3] <= vdata_reg.spanning_tree_instance;
            reg_rdata[FID_MSB:FID_LSB] <= vdata_reg.filter_group_id;
          end
          ADDR_VLAN_ENTRY1: reg_rdata[V_PORT_MSB:0] <= vdata_reg.untag_mask;
          ADDR_VLAN_ENTRY2: reg_rdata[V_PORT_MSB:0] <= vdata_reg.member_mask;
          ADDR_VLAN_INDEX: reg_rdata[VIDX_MSB:0] <= vidx_reg;
          ADDR_VLAN_CTRL: begin
            reg_rdata[GO_BIT] <= vlan_go_reg;
            reg_rdata[ACTION_BIT] <= vlan_read_reg;
          end
          default: reg_rdata <= ZERO_WORD;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// file: sim/switch_table_indirect_access_sva.sv
`timescale 1ns/1ps
`default_nettype none
module switch_table_indirect_access_sva
  import switch_table_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic vlan_mode_en,
  input wire logic vlan_lookup_req,
  input wire logic vlan_lookup_valid,
  input wire vlan_entry_t vlan_lookup_entry,
  input wire logic sta_lookup_req,
  input wire logic sta_lookup_valid,
  input wire logic sta_lookup_hit,
  input wire logic [5:0] sta_lookup_fwd,
  input wire logic [5:0] rmc_lookup_addr,
  input wire logic [5:0] rmc_lookup_fwd
);
  // Every answer comes one cycle after its request
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  a_read_answer:
    assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  a_read_cause:
    assert property (reg_rvalid |-> $past(reg_rd)) else $error("read valid without read");
  a_rdata_hold:
    assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  a_vlan_answer:
    assert property (vlan_lookup_req && vlan_mode_en |=> vlan_lookup_valid)
      else $error("vlan lookup not answered");
  a_vlan_refused:
    assert property (vlan_lookup_valid |-> $past(vlan_lookup_req) && $past(vlan_mode_en))
      else $error("vlan answer without enabled request");
  a_entry_hold:
    assert property (!vlan_lookup_req |=> $stable(vlan_lookup_entry))
      else $error("vlan entry moved");
  a_sta_answer:
    assert property (sta_lookup_req |=> sta_lookup_valid) else $error("static lookup lost");
  a_miss_no_fwd:
    assert property (sta_lookup_valid && !sta_lookup_hit |-> sta_lookup_fwd == 6'h00)
      else $error("forward mask on miss");
  a_rmc_range:
    assert property (rmc_lookup_addr > 6'h2F |=> rmc_lookup_fwd == 6'h00)
      else $error("reserved mask beyond 48");
  // Main scenarios reached
  c_vlan_hit: cover property (vlan_lookup_valid && vlan_lookup_entry.valid);
  c_sta_hit: cover property (sta_lookup_valid && sta_lookup_hit);
  c_rmc_fwd: cover property (rmc_lookup_fwd != 6'h00);
endmodule
bind switch_table_indirect_access switch_table_indirect_access_sva i_sva (
  .mclk, .srst, .reg_rd, .reg_rdata, .reg_rvalid, .vlan_mode_en, .vlan_lookup_req,
  .vlan_lookup_valid, .vlan_lookup_entry, .sta_lookup_req, .sta_lookup_valid,
  .sta_lookup_hit, .sta_lookup_fwd, .rmc_lookup_addr, .rmc_lookup_fwd
);
`default_nettype wire

// file: sim/switch_table_indirect_access_tb.sv
`timescale 1ns/1ps
`default_nettype none
module switch_table_indirect_access_tb
  import switch_table_pkg::*;
;
  logic mclk = 0, srst = 1, reg_wr = 0, reg_rd = 0, vlan_mode_en = 0, vlan_lookup_req = 0;
  logic sta_lookup_req = 0, sta_lookup_mcast = 0, reg_rvalid, vlan_lookup_valid;
  logic sta_lookup_valid, sta_lookup_hit, mc, hit;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, w2[16], w3[16], w4[16];
  logic [11:0] vlan_lookup_vid = 12'h000;
  logic [47:0] sta_lookup_mac = 48'h0;
  logic [6:0] sta_lookup_fid = 7'h00, fd, sx;
  logic [5:0] port_state_fwd = 6'h00, rmc_lookup_addr = 6'h00, sta_lookup_fwd, rmc_lookup_fwd;
  logic [5:0] ps, gm[8];
  logic [95:0] vw[2];
  logic [63:0] e, rq[$], vq[$], sq[$];
  vlan_entry_t vlan_lookup_entry;
  int seed = 16, err_count = 0, n_compared = 0;

  switch_table_indirect_access i_dut (.mclk, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .vlan_mode_en, .vlan_lookup_req, .vlan_lookup_vid,
    .vlan_lookup_valid, .vlan_lookup_entry, .sta_lookup_req, .sta_lookup_mac, .sta_lookup_fid,
    .sta_lookup_mcast, .port_state_fwd, .sta_lookup_valid, .sta_lookup_hit, .sta_lookup_fwd,
    .rmc_lookup_addr, .rmc_lookup_fwd);

  // Clock
  initial forever #12.5 mclk = ~mclk;

  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One compare per kind of result
  task automatic cmp_read(input logic [31:0] got, input logic [31:0] exp);
    cmp(got, exp, "read");
  endtask

  task automatic cmp_vlan(input vlan_entry_t got, input logic [28:0] exp);
    cmp(got, exp, "vlan");
  endtask

  task automatic cmp_sta(input logic [6:0] got, input logic [6:0] exp);
    cmp(got, exp, "sta");
  endtask

  task automatic cmp_rmc(input logic [5:0] got, input logic [5:0] exp);
    cmp(got, exp, "rmc");
  endtask

  // Register access; a read notes its masked expectation first
  task automatic acc(input logic rd, input logic [15:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    if (rd) rq.push_back({m, d & m});
    @(posedge mclk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_rd = rd;
    reg_wr = !rd;
    @(posedge mclk) #1;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
  endtask

  // Start a table access, wait the worst completion, then see go_done clear
  task automatic op(input logic [15:0] a, input logic [31:0] c);
    acc(1'b0, a, c, 32'h0);
    repeat (4) @(posedge mclk);
    acc(1'b1, a, 32'h0, 32'h0000_0080);
  endtask

  task automatic vlook(input logic [11:0] vid, input logic [95:0] w);
    if (vlan_mode_en) vq.push_back({w[95:88], w[86:80], w[38:32], w[6:0]});
    @(posedge mclk) #1;
    vlan_lookup_vid = vid;
    vlan_lookup_req = 1'b1;
    @(posedge mclk) #1;
    vlan_lookup_req = 1'b0;
  endtask

  task automatic slook(input logic [47:0] mac, input logic [6:0] exp);
    sq.push_back(exp);
    @(posedge mclk) #1;
    sta_lookup_mac = mac;
    sta_lookup_fid = fd;
    sta_lookup_mcast = mc;
    port_state_fwd = ps;
    sta_lookup_req = 1'b1;
    @(posedge mclk) #1;
    sta_lookup_req = 1'b0;
  endtask

  // Watcher takes the oldest note whenever a result appears
  always @(posedge mclk) begin
    if (reg_rvalid === 1'b1) begin
      e = rq.size() ? rq.pop_front() : 'x;
      cmp_read(reg_rdata & e[63:32], e[31:0]);
    end
    if (vlan_lookup_valid === 1'b1) begin
      e = vq.size() ? vq.pop_front() : 'x;
      cmp_vlan(vlan_lookup_entry, e[28:0]);
    end
    if (sta_lookup_valid === 1'b1) begin
      e = sq.size() ? sq.pop_front() : 'x;
      cmp_sta({sta_lookup_hit, sta_lookup_fwd}, e[6:0]);
    end
  end

  // Hang guard
  initial begin
    repeat (50000) @(posedge mclk);
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge mclk);
    #1 srst = 1'b0;
    acc(1'b1, 16'h0420, 32'h0, 32'hFFFF_FFFF);
    for (int i = 0; i < 16; i++) begin
      w2[i] = $random(seed);
      w3[i] = {9'h000, 7'($random(seed)), 16'hA5A5};
      w4[i] = {28'($random(seed)), 4'(i)};
      acc(1'b0, ADDR_STA_WORD2, w2[i], 32'h0);
      acc(1'b0, ADDR_STA_WORD3, w3[i], 32'h0);
      acc(1'b0, ADDR_STA_WORD4, w4[i], 32'h0);
      op(ADDR_STA_CTRL, {18'h0, 6'(i), 8'h80});
    end
    for (int k = 0; k < 16; k += 15) begin
      op(ADDR_STA_CTRL, {18'h0, 6'(k), 8'h81});
      acc(1'b1, ADDR_STA_WORD2, w2[k], 32'hC000_003F);
      acc(1'b1, ADDR_STA_WORD3, w3[k], 32'hFFFF_FFFF);
      acc(1'b1, ADDR_STA_WORD4, w4[k], 32'hFFFF_FFFF);
    end
    for (int i = 0; i < 16; i++) begin
      mc = 1'($random(seed));
      fd = 7'($random(seed));
      ps = 6'($random(seed));
      hit = !(mc && w2[i][30] && fd != w3[i][22:16]);
      sx = {hit, hit ? w2[i][5:0] & (w2[i][31] ? 6'h3F : ps) : 6'h00};
      slook({w3[i][15:0], w4[i]}, sx);
    end
    slook(48'h0, 7'h00);
    // One write per group, at a random member of the group
    for (int g = 0; g < 8; g++) begin
      gm[g] = 6'($random(seed));
      acc(1'b0, ADDR_STA_WORD2, {26'h0, gm[g]}, 32'h0);
      op(ADDR_STA_CTRL, {18'h0, 6'(g * 6 + $unsigned($random(seed)) % 6), 8'h90});
    end
    op(ADDR_STA_CTRL, {18'h0, 6'h17, 8'h91});
    acc(1'b1, ADDR_STA_WORD2, {26'h0, gm[3]}, 32'hFFFF_FFFF);
    for (int a = 0; a < 64; a++) begin
      @(posedge mclk) #1;
      rmc_lookup_addr = 6'(a);
      @(posedge mclk) #1;
      cmp_rmc(rmc_lookup_fwd, a < 48 ? gm[a / 6] : 6'h00);
    end
    for (int v = 0; v < 2; v++) begin
      vw[v] = {$random(seed), $random(seed), $random(seed)};
      acc(1'b0, ADDR_VLAN_ENTRY0, vw[v][95:64], 32'h0);
      acc(1'b0, ADDR_VLAN_ENTRY1, vw[v][63:32], 32'h0);
      acc(1'b0, ADDR_VLAN_ENTRY2, vw[v][31:0], 32'h0);
      acc(1'b0, ADDR_VLAN_INDEX, {20'h0, {12{v[0]}}}, 32'h0);
      op(ADDR_VLAN_CTRL, 32'h0000_0080);
    end
    acc(1'b0, ADDR_VLAN_INDEX, 32'h0, 32'h0);
    op(ADDR_VLAN_CTRL, 32'h0000_0081);
    acc(1'b1, ADDR_VLAN_ENTRY0, vw[0][95:64], 32'hFF7F_0000);
    acc(1'b1, ADDR_VLAN_ENTRY1, vw[0][63:32], 32'h0000_007F);
    acc(1'b1, ADDR_VLAN_ENTRY2, vw[0][31:0], 32'h0000_007F);
    vlook(12'h000, vw[0]);
    vlan_mode_en = 1'b1;
    vlook(12'h000, vw[0]);
    vlook(12'hFFF, vw[1]);
    repeat (4) @(posedge mclk);
    if (rq.size() + vq.size() + sq.size() != 0) err_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
